// ### dv/ocs_clock_select_asserts.sv
// port-level assertions for the clock select block
// assumes it is bound to ocs_clock_select and sees only its ports
`timescale 1ns/1ns
module ocs_clock_select_asserts #(
    parameter NEW_WAIT = 4
) (
    input wire SYS_CLK,
    input wire RESETN,
    input wire SLEEP_EXEC,
    input wire [1:0] CLK_SRC,
    input wire CLK_RUN,
    input wire [2:0] INT_FREQ_SEL,
    input wire INT_LF_FROM_FAST,
    input wire PLL_ON,
    input wire WDT_FROM_SLOW_RC,
    input wire IDLE_ENTER,
    input wire SLEEP_ENTER
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // slowest new-source tick is eight cycles apart, so the pause is bounded
    sequence pause_then_run;
        !CLK_RUN ##[1:60] CLK_RUN;
    endsequence
    // the run flag drops on entry to the pause, the source moves after two old ticks
    sequence src_follows;
        ##[1:40] $changed(CLK_SRC);
    endsequence
    sequence sleep_out;
        ##[2:8] (IDLE_ENTER || SLEEP_ENTER);
    endsequence
    chk_wdt_slow: assert property (WDT_FROM_SLOW_RC)
        else $error("watchdog clock not from slow rc");
    chk_pll_freq: assert property (PLL_ON |-> INT_FREQ_SEL[2:1] == 2'h3)
        else $error("pll on at low frequency code");
    chk_lf_code: assert property (INT_LF_FROM_FAST |-> INT_FREQ_SEL == 3'h0)
        else $error("divided source outside code 000");
    chk_reset_src: assert property ($rose(RESETN) |-> CLK_SRC == 2'h0 && INT_FREQ_SEL == 3'h4)
        else $error("reset values of source or frequency wrong");
    chk_switch_pause: assert property ($changed(CLK_SRC) |-> pause_then_run)
        else $error("switch pause missing or too long");
    chk_run_cause: assert property ($fell(CLK_RUN) |-> src_follows)
        else $error("clock stopped without a switch");
    chk_sleep_one: assert property (!(IDLE_ENTER && SLEEP_ENTER))
        else $error("idle and sleep together");
    chk_sleep_resp: assert property ($rose(SLEEP_EXEC) |-> sleep_out)
        else $error("no response to sleep instruction");
endmodule // ocs_clock_select_asserts
bind ocs_clock_select ocs_clock_select_asserts #(.NEW_WAIT(NEW_WAIT)) ocs_chk_inst (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SLEEP_EXEC(SLEEP_EXEC), .CLK_SRC(CLK_SRC),
    .CLK_RUN(CLK_RUN), .INT_FREQ_SEL(INT_FREQ_SEL), .INT_LF_FROM_FAST(INT_LF_FROM_FAST),
    .PLL_ON(PLL_ON), .WDT_FROM_SLOW_RC(WDT_FROM_SLOW_RC), .IDLE_ENTER(IDLE_ENTER),
    .SLEEP_ENTER(SLEEP_ENTER));

// ### dv/tb.sv
// self-checking bench for the clock select block, driven over apb
// assumes one 100 MHz clock; source ticks are made here as slow square waves
`timescale 1ns/1ns
`include "ocs_defines.vh"
module tb;
    reg SYS_CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    reg [31:0] PADDR = 0, PWDATA = 0;
    reg PRI_TICK = 0, SEC_TICK = 0, INT_TICK = 0, SLEEP_EXEC = 0;
    reg PRI_STARTUP_DONE_IN = 1, INT_STABLE_IN = 1;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, CLK_RUN, INT_LF_FROM_FAST, PLL_ON, WDT_FROM_SLOW_RC;
    wire IDLE_ENTER, SLEEP_ENTER;
    wire [1:0] CLK_SRC;
    wire [2:0] INT_FREQ_SEL;
    wire [4:0] FAST_TRIM;
    reg [31:0] rd;
    reg rerr, seen;
    reg [3:0] cfgs [0:3];
    reg [7:0] cnt = 0;
    integer err_total = 0, samples_checked = 0, cyc = 0, c, f, i;
    ocs_clock_select ocs_clock_select_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PRI_TICK(PRI_TICK), .SEC_TICK(SEC_TICK),
        .INT_TICK(INT_TICK), .PRI_STARTUP_DONE_IN(PRI_STARTUP_DONE_IN),
        .INT_STABLE_IN(INT_STABLE_IN), .SLEEP_EXEC(SLEEP_EXEC), .CLK_SRC(CLK_SRC),
        .CLK_RUN(CLK_RUN), .INT_FREQ_SEL(INT_FREQ_SEL), .INT_LF_FROM_FAST(INT_LF_FROM_FAST),
        .PLL_ON(PLL_ON), .FAST_TRIM(FAST_TRIM), .WDT_FROM_SLOW_RC(WDT_FROM_SLOW_RC),
        .IDLE_ENTER(IDLE_ENTER), .SLEEP_ENTER(SLEEP_ENTER));
    always #5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK)
    begin
        cnt <= cnt + 8'h01;
        INT_TICK <= cnt[1];
        PRI_TICK <= cnt[1];
        SEC_TICK <= cnt[2];
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total = err_total + 1;
            results;
        end
    end
    task results;
    begin
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // reads right after an edge see what that edge sampled, as the design updates later
    task apb(input w, input [31:0] a, input [31:0] d);
    begin
        @(posedge SYS_CLK);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1;
        seen = 0;
        while (!seen)
        begin
            @(posedge SYS_CLK);
            seen = PREADY;
            rd = PRDATA;
            rerr = PSLVERR;
        end
        PSEL <= 0;
        PENABLE <= 0;
    end
    endtask
    // registered outputs follow a stored write one edge later
    task settle;
    begin
        repeat (2) @(posedge SYS_CLK);
    end
    endtask
    task wsrc(input [1:0] s);
    begin
        i = 0;
        while (!(CLK_SRC === s && CLK_RUN === 1'b1) && i < 300)
        begin
            @(negedge SYS_CLK);
            i = i + 1;
        end
    end
    endtask
    initial
    begin
        cfgs[0] = 4'h8;
        cfgs[1] = 4'h9;
        cfgs[2] = 4'h6;
        cfgs[3] = 4'h0;
        repeat (16) @(posedge SYS_CLK);
        RESETN <= 1;
        apb(0, `OCS_OFF_TUNE, 0); chk(rd, 32'h00);
        apb(0, `OCS_OFF_CTRL, 0); chk(rd, 32'h48);
        apb(0, `OCS_OFF_T1CTL, 0); chk(rd, 32'h00);
        apb(1, `OCS_OFF_TUNE, 32'hFF);
        apb(0, `OCS_OFF_TUNE, 0); chk(rd, 32'h9F);
        chk({27'h0, FAST_TRIM}, 32'h1F);
        for (c = 0; c < 4; c = c + 1)
        begin
            apb(1, `OCS_OFF_CFG, {28'h0, cfgs[c]});
            for (f = 0; f < 8; f = f + 1)
            begin
                apb(1, `OCS_OFF_CTRL, f << 4);
                apb(1, `OCS_OFF_TUNE, 32'h40);
                apb(0, `OCS_OFF_TUNE, 0);
                seen = (c < 2) && (f > 5);
                chk(rd & 32'h40, seen ? 32'h40 : 32'h00);
                chk({31'h0, PLL_ON}, {31'h0, seen});
                chk({29'h0, INT_FREQ_SEL}, f);
            end
        end
        apb(1, `OCS_OFF_TUNE, 32'h00);
        settle;
        chk({31'h0, PLL_ON}, 32'h0);
        apb(1, `OCS_OFF_CTRL, 32'h00);
        apb(1, `OCS_OFF_TUNE, 32'h80);
        settle;
        chk({31'h0, INT_LF_FROM_FAST}, 32'h1);
        apb(1, `OCS_OFF_TUNE, 32'h00);
        settle;
        chk({31'h0, INT_LF_FROM_FAST}, 32'h0);
        apb(1, `OCS_OFF_CTRL, 32'hE1);
        apb(0, `OCS_OFF_CTRL, 0); chk(rd & 32'h3, 32'h0);
        apb(0, 32'h10, 0); chk({rd[30:0], rerr}, 32'h1);
        apb(1, `OCS_OFF_T1CTL, 32'h08);
        apb(1, `OCS_OFF_CTRL, 32'hE1);
        wsrc(2'h1); chk({30'h0, CLK_SRC}, 32'h1);
        apb(0, `OCS_OFF_T1CTL, 0); chk(rd & 32'h48, 32'h48);
        apb(0, `OCS_OFF_CTRL, 0); chk(rd & 32'hC, 32'h0);
        apb(1, `OCS_OFF_CTRL, 32'hE2);
        wsrc(2'h2); chk({30'h0, CLK_SRC}, 32'h2);
        apb(0, `OCS_OFF_CTRL, 0); chk(rd & 32'hC, 32'h4);
        for (c = 0; c < 2; c = c + 1)
        begin
            apb(1, `OCS_OFF_CTRL, {c[0], 7'h62});
            SLEEP_EXEC <= 1;
            seen = 0;
            for (i = 0; i < 10; i = i + 1)
            begin
                @(negedge SYS_CLK);
                seen = seen | (c ? IDLE_ENTER : SLEEP_ENTER);
            end
            SLEEP_EXEC <= 0;
            chk({31'h0, seen}, 32'h1);
        end
        @(posedge SYS_CLK);
        RESETN <= 0;
        @(posedge SYS_CLK);
        RESETN <= 1;
        chk({27'h0, CLK_SRC, INT_FREQ_SEL}, 32'h4);
        chk({31'h0, WDT_FROM_SLOW_RC}, 32'h1);
        results;
    end
endmodule // tb

// ### verilog/ocs_clock_select.v
// clock source selection, internal oscillator frequency/PLL control and tuning register
// assumes an APB master on SYS_CLK; source ticks are levels held for at least two SYS_CLK cycles, synchronised here
`timescale 1ns/1ns
`include "ocs_defines.vh"
module ocs_clock_select #(
    parameter NEW_WAIT = `OCS_NEW_CYC
) (
    input wire SYS_CLK,
    input wire RESETN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire PRI_TICK,
    input wire SEC_TICK,
    input wire INT_TICK,
    input wire PRI_STARTUP_DONE_IN,
    input wire INT_STABLE_IN,
    input wire SLEEP_EXEC,
    output reg [1:0] CLK_SRC,
    output reg CLK_RUN,
    output reg [2:0] INT_FREQ_SEL,
    output reg INT_LF_FROM_FAST,
    output reg PLL_ON,
    output reg [4:0] FAST_TRIM,
    output reg WDT_FROM_SLOW_RC,
    output reg IDLE_ENTER,
    output reg SLEEP_ENTER
);
    localparam ST_RUN = 3'b001;
    localparam ST_OLD = 3'b010;
    localparam ST_NEW = 3'b100;

    reg [7:0] tune_reg;
    reg [2:0] ircf_reg;
    reg idle_reg;
    reg [1:0] scs_reg;
    reg t1en_reg;
    reg [3:0] cfg_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [2:0] cnt_reg;
    reg [2:0] cnt_next;
    reg [1:0] act_reg;
    reg [1:0] act_next;
    reg [2:0] pri_s_reg;
    reg [2:0] sec_s_reg;
    reg [2:0] int_s_reg;
    reg [2:0] pst_s_reg;
    reg [2:0] ist_s_reg;
    reg [2:0] slp_s_reg;
    reg pri_q_reg;
    reg sec_q_reg;
    reg int_q_reg;
    reg pst_q_reg;
    reg ist_q_reg;
    reg slp_q_reg;
    reg [31:0] rdata_next;

    // status flags follow the source actually in use, not the requested one,
    // so at most one of them can be set at a time
    wire pri_ready_flag;
    wire int_stable_flag;
    wire sec_active_flag;

    wire wr_acc = PSEL & PENABLE & PWRITE;
    // read data is fetched in the setup cycle so that it stands together with PREADY
    wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
    wire [3:0] off = PADDR[3:0];
    wire addr_ok = (PADDR[31:4] == 28'h0000000) & (off[1:0] == 2'h0);

    // pll allowed in this configuration and frequency
    function pll_avail;
        input [3:0] cfg;
        input [2:0] ircf;
        begin
            pll_avail = ((cfg == `OCS_CFG_INT_A) || (cfg == `OCS_CFG_INT_B)) &&
                ((ircf == `OCS_IRCF_8M) || (ircf == `OCS_IRCF_4M));
        end
    endfunction

    // tick of the source with the given select code, after synchronising
    function src_tick;
        input [1:0] code;
        input p;
        input s;
        input i;
        begin
            if (code[1])
                src_tick = i;
            else if (code[0])
                src_tick = s;
            else
                src_tick = p;
        end
    endfunction

    // one-cycle event on a synchronised rising edge; a change counts only once
    // the second and third stages agree, which filters a single-cycle glitch
    function edge_seen;
        input [2:0] s;
        input q;
        begin
            edge_seen = s[1] & s[2] & ~q;
        end
    endfunction

    wire avail = pll_avail(cfg_reg, ircf_reg);
    wire pll_rd = tune_reg[`OCS_TUNE_PLL_ENABLE_BIT] & avail;
    wire pri_t = edge_seen(pri_s_reg, pri_q_reg);
    wire sec_t = edge_seen(sec_s_reg, sec_q_reg);
    wire int_t = edge_seen(int_s_reg, int_q_reg);
    wire slp_t = edge_seen(slp_s_reg, slp_q_reg);
    assign pri_ready_flag = pst_q_reg & (act_reg == `OCS_SCS_PRI);
    assign int_stable_flag = ist_q_reg & act_reg[1];
    assign sec_active_flag = t1en_reg & (act_reg == `OCS_SCS_SEC);

    always @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            pri_s_reg <= 3'h0;
            sec_s_reg <= 3'h0;
            int_s_reg <= 3'h0;
            pst_s_reg <= 3'h0;
            ist_s_reg <= 3'h0;
            slp_s_reg <= 3'h0;
            pri_q_reg <= 1'b0;
            sec_q_reg <= 1'b0;
            int_q_reg <= 1'b0;
            pst_q_reg <= 1'b0;
            ist_q_reg <= 1'b0;
            slp_q_reg <= 1'b0;
        end
        else
        begin
            pri_s_reg <= {pri_s_reg[1:0], PRI_TICK};
            sec_s_reg <= {sec_s_reg[1:0], SEC_TICK};
            int_s_reg <= {int_s_reg[1:0], INT_TICK};
            pst_s_reg <= {pst_s_reg[1:0], PRI_STARTUP_DONE_IN};
            ist_s_reg <= {ist_s_reg[1:0], INT_STABLE_IN};
            slp_s_reg <= {slp_s_reg[1:0], SLEEP_EXEC};
            if (pri_s_reg[1] == pri_s_reg[2])
                pri_q_reg <= pri_s_reg[2];
            if (sec_s_reg[1] == sec_s_reg[2])
                sec_q_reg <= sec_s_reg[2];
            if (int_s_reg[1] == int_s_reg[2])
                int_q_reg <= int_s_reg[2];
            if (pst_s_reg[1] == pst_s_reg[2])
                pst_q_reg <= pst_s_reg[2];
            if (ist_s_reg[1] == ist_s_reg[2])
                ist_q_reg <= ist_s_reg[2];
            if (slp_s_reg[1] == slp_s_reg[2])
                slp_q_reg <= slp_s_reg[2];
        end
    end

    // registers; the configuration word stands in for fuses and is software written here
    always @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tune_reg <= `OCS_TUNE_RST;
            ircf_reg <= `OCS_IRCF_RST;
            idle_reg <= 1'b0;
            scs_reg <= `OCS_SCS_PRI;
            t1en_reg <= 1'b0;
            cfg_reg <= `OCS_CFG_RST;
        end
        else if (wr_acc && addr_ok)
        begin
            case (off)
                `OCS_OFF_TUNE:
                begin
                    // bit 5 never stored
                    tune_reg <= {PWDATA[7:6], 1'b0, PWDATA[4:0]};
                end
                `OCS_OFF_CTRL:
                begin
                    idle_reg <= PWDATA[`OCS_CTRL_IDLE];
                    ircf_reg <= PWDATA[6:4];
                    // secondary request dropped unless its oscillator is enabled
                    if (!(PWDATA[1:0] == `OCS_SCS_SEC && !t1en_reg))
                        scs_reg <= PWDATA[1:0];
                end
                `OCS_OFF_T1CTL:
                    t1en_reg <= PWDATA[`OCS_T1_OSCEN];
                `OCS_OFF_CFG:
                    cfg_reg <= PWDATA[3:0];
                default:
                    cfg_reg <= cfg_reg;
            endcase
        end
    end

    // switch sequence: stop on old-source ticks, restart on new-source ticks
    always @*
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        act_next = act_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (scs_reg != act_reg)
                begin
                    state_next = ST_OLD;
                    cnt_next = 3'h0;
                end
            end
            ST_OLD:
            begin
                // a dead old source stalls the switch here; the pause needs its ticks
                if (src_tick(act_reg, pri_t, sec_t, int_t))
                begin
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == `OCS_OLD_CYC - 1)
                    begin
                        state_next = ST_NEW;
                        cnt_next = 3'h0;
                        act_next = scs_reg;
                    end
                end
            end
            ST_NEW:
            begin
                if (src_tick(act_reg, pri_t, sec_t, int_t))
                begin
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == NEW_WAIT - 1)
                        state_next = ST_RUN;
                end
            end
            default:
                state_next = ST_RUN;
        endcase
    end

    // read mux; unmapped or misaligned offsets read zero
    always @*
    begin
        rdata_next = 32'h00000000;
        if (rd_setup && addr_ok)
        begin
            case (off)
                `OCS_OFF_TUNE:
                begin
                    // the pll bit shows zero wherever the pll cannot run
                    rdata_next = {24'h000000, tune_reg[7], pll_rd, 1'b0, tune_reg[4:0]};
                end
                `OCS_OFF_CTRL:
                begin
                    rdata_next = {24'h000000, idle_reg, ircf_reg, pri_ready_flag,
                        int_stable_flag, scs_reg};
                end
                `OCS_OFF_T1CTL:
                begin
                    rdata_next = {24'h000000, 1'b0, sec_active_flag, 2'h0, t1en_reg, 3'h0};
                end
                `OCS_OFF_CFG:
                begin
                    rdata_next = {28'h0000000, cfg_reg};
                end
                default:
                begin
                    rdata_next = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= ST_RUN;
            cnt_reg <= 3'h0;
            act_reg <= `OCS_SCS_PRI;
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            CLK_SRC <= `OCS_SCS_PRI;
            CLK_RUN <= 1'b1;
            INT_FREQ_SEL <= `OCS_IRCF_RST;
            INT_LF_FROM_FAST <= 1'b0;
            PLL_ON <= 1'b0;
            FAST_TRIM <= 5'h00;
            WDT_FROM_SLOW_RC <= 1'b1;
            IDLE_ENTER <= 1'b0;
            SLEEP_ENTER <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            act_reg <= act_next;
            // no wait state: answer in the first access cycle after setup
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
            PRDATA <= rdata_next;
            // source and run flag come from the next state so each moves on the same edge as act_reg or state_reg
            CLK_SRC <= act_next;
            CLK_RUN <= (state_next == ST_RUN);
            INT_FREQ_SEL <= ircf_reg;
            INT_LF_FROM_FAST <= (ircf_reg == `OCS_IRCF_LF) & tune_reg[`OCS_TUNE_LFSRC];
            PLL_ON <= pll_rd;
            FAST_TRIM <= tune_reg[4:0];
            // watchdog never follows the device clock select
            WDT_FROM_SLOW_RC <= 1'b1;
            IDLE_ENTER <= slp_t & idle_reg;
            SLEEP_ENTER <= slp_t & ~idle_reg;
        end
    end
endmodule // ocs_clock_select

// ### verilog/ocs_defines.vh
// register offsets, field positions, reset values and codes of the clock select block
// included by ocs_clock_select.v; no logic here
`ifndef OCS_DEFINES_VH
`define OCS_DEFINES_VH
`define OCS_ADDR_W 4
`define OCS_OFF_TUNE 4'h0
`define OCS_OFF_CTRL 4'h4
`define OCS_OFF_T1CTL 4'h8
`define OCS_OFF_CFG 4'hC
`define OCS_TUNE_LFSRC 7
`define OCS_TUNE_PLL_ENABLE_BIT 6
`define OCS_TUNE_RSVD 5
`define OCS_CTRL_IDLE 7
`define OCS_CTRL_STARTUP 3
`define OCS_CTRL_IFSTABLE 2
`define OCS_T1_ACTIVE 6
`define OCS_T1_OSCEN 3
`define OCS_TUNE_RST 8'h00
`define OCS_IRCF_RST 3'h4
`define OCS_CFG_RST 4'h0
`define OCS_CFG_INT_A 4'h9
`define OCS_CFG_INT_B 4'h8
`define OCS_IRCF_8M 3'h7
`define OCS_IRCF_4M 3'h6
`define OCS_IRCF_LF 3'h0
`define OCS_SCS_PRI 2'h0
`define OCS_SCS_SEC 2'h1
`define OCS_PLL_MULT 4
`define OCS_PLL_MAX_MHZ 32
`define OCS_LF_DIV 256
`define OCS_OLD_CYC 2
`define OCS_NEW_CYC 4
`endif
